// ==== sdw_pkg.sv ====
// Configuration, derived widths and beat layout of the width converter
package sdw_pkg;
  // ==========================================================
  // Configuration
  localparam int IN_BYTES   = 1;
  localparam int OUT_BYTES  = 2;
  localparam int STRB_EN    = 0;
  localparam int KEEP_EN    = 0;
  localparam int LAST_EN    = 0;
  localparam int ID_W       = 0;
  localparam int DEST_W     = 0;
  localparam int USER_BPB   = 0;
  localparam int ACLKEN_EN  = 0;
  localparam int FIFO_DEPTH = 8;
  localparam int MIN_BYTES  = 1;
  localparam int MAX_BYTES  = 512;
  localparam int MAX_SIDE_W = 32;
  localparam int BYTE_W     = 8;

  // ==========================================================
  // Derived widths
  localparam int IN_W    = IN_BYTES * BYTE_W;
  localparam int OUT_W   = OUT_BYTES * BYTE_W;
  localparam bit UPSIZE  = OUT_BYTES > IN_BYTES;
  localparam int WIDE_B  = UPSIZE ? OUT_BYTES : IN_BYTES;
  localparam int NARR_B  = UPSIZE ? IN_BYTES : OUT_BYTES;
  localparam int WIDE_W  = WIDE_B * BYTE_W;
  localparam int RATIO   = WIDE_B / NARR_B;
  localparam int IDX_W   = RATIO > 2 ? $clog2(RATIO) : 1;
  localparam int ID_PW   = ID_W > 0 ? ID_W : 1;
  localparam int DEST_PW = DEST_W > 0 ? DEST_W : 1;
  localparam int UB_PW   = USER_BPB > 0 ? USER_BPB : 1;
  // An early packet end while widening leaves empty output lanes
  localparam bit NULL_BYTES = UPSIZE && LAST_EN != 0;
  localparam bit KEEP_OUT   = KEEP_EN != 0 || NULL_BYTES;
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(RATIO - 1);
  localparam logic [IDX_W-1:0] IDX_ONE  = IDX_W'(1);

  // ==========================================================
  // One input beat as it is queued
  typedef struct packed {
    logic [IN_W-1:0]           data;
    logic [IN_BYTES-1:0]       keep;
    logic [IN_BYTES-1:0]       strb;
    logic [IN_BYTES*UB_PW-1:0] user;
    logic                      last;
    logic [ID_PW-1:0]          id;
    logic [DEST_PW-1:0]        dest;
  } sdw_beat_t;
  localparam int BEAT_W = $bits(sdw_beat_t);
endpackage

// ==== sdw_fifo_if.sv ====
// Handshake bundle between the converter and its input queue
`timescale 1ns/10ps
interface sdw_fifo_if #(parameter int W = 8);
  logic [W-1:0] in_data;
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] out_data;
  logic         out_valid;
  logic         out_ready;
  logic         ce;
  modport fifo (input in_data, in_valid, out_ready, ce,
                output in_ready, out_data, out_valid);
  modport user (output in_data, in_valid, out_ready, ce,
                input in_ready, out_data, out_valid);
endinterface

// ==== sdw_fifo.sv ====
// Beat queue with valid and ready on both sides
`timescale 1ns/10ps
module sdw_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic   sys_clk,
  input  wire logic   resetn,
  sdw_fifo_if.fifo    q
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] CNT_FULL = (PW + 1)'(DEPTH);
  localparam logic [PW:0] CNT_ZERO = '0;

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0]   cnt;
    logic          rdy;
    logic          vld;
  } sdw_fifo_st_t;

  // ==========================================================
  // State
  sdw_fifo_st_t r;
  sdw_fifo_st_t n;
  logic [W-1:0] mem [DEPTH];
  logic         push;
  logic         pop;

  assign push       = q.ce && q.in_valid && r.rdy;
  assign pop        = q.ce && q.out_ready && r.vld;
  assign q.in_ready = r.rdy;
  assign q.out_valid = r.vld;
  assign q.out_data = mem[r.rp];

  always_comb begin
    n = r;
    if (push) begin
      n.wp = r.wp + PW'(1);
    end
    if (pop) begin
      n.rp = r.rp + PW'(1);
    end
    n.cnt = r.cnt + (PW + 1)'(push) - (PW + 1)'(pop);
    // Ready is registered so a full queue stalls the source cleanly
    n.rdy = n.cnt != CNT_FULL;
    n.vld = n.cnt != CNT_ZERO;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.rdy <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Payload storage needs no reset
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[r.wp] <= q.in_data;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_fifo_bound;
    r.cnt == CNT_FULL |-> !r.rdy ##1 r.cnt <= CNT_FULL;
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) // [RULE12]
    else $error("queue count passed its depth");

  property p_fifo_pop;
    pop && !push |=> r.cnt == $past(r.cnt) - (PW + 1)'(1);
  endproperty
  a_fifo_pop: assert property (p_fifo_pop) // [RULE12]
    else $error("queue count did not drop on pop");
endmodule // sdw_fifo

// ==== sdw_conv.sv ====
// Stream width converter: queue, repacking and registered output
`timescale 1ns/10ps
// How it works
// [RULE1] Input width is 1 to 512 bytes
// [RULE2] Output width is 1 to 512 bytes
// [RULE3] Equal input and output widths are rejected
// [RULE4] Output keep provided whenever null bytes possible
// [RULE5] Strobe on both ports or neither
// [RULE6] Packet end on both ports or neither
// [RULE7] Stream id present only when width nonzero
// [RULE8] Destination present only when width nonzero
// [RULE9] User bits present only when width nonzero
// [RULE10] Optional clock enable accompanies the clock
// [RULE11] Lowest bytes first; sideband follows its bytes
// [RULE12] Clock enable low freezes everything; payload held
module sdw_conv (
  input  wire logic                                    sys_clk,
  input  wire logic                                    resetn,
  input  wire logic                                    aclken,
  input  wire logic [sdw_pkg::IN_W-1:0]                s_tdata,
  input  wire logic [sdw_pkg::IN_BYTES-1:0]            s_tkeep,
  input  wire logic [sdw_pkg::IN_BYTES-1:0]            s_tstrb,
  input  wire logic                                    s_tlast,
  input  wire logic [sdw_pkg::ID_PW-1:0]               s_tid,
  input  wire logic [sdw_pkg::DEST_PW-1:0]             s_tdest,
  input  wire logic [sdw_pkg::IN_BYTES*sdw_pkg::UB_PW-1:0]  s_tuser,
  input  wire logic                                    s_tvalid,
  output wire logic                                    s_tready,
  output wire logic [sdw_pkg::OUT_W-1:0]               m_tdata,
  output wire logic [sdw_pkg::OUT_BYTES-1:0]           m_tkeep,
  output wire logic [sdw_pkg::OUT_BYTES-1:0]           m_tstrb,
  output wire logic                                    m_tlast,
  output wire logic [sdw_pkg::ID_PW-1:0]               m_tid,
  output wire logic [sdw_pkg::DEST_PW-1:0]             m_tdest,
  output wire logic [sdw_pkg::OUT_BYTES*sdw_pkg::UB_PW-1:0] m_tuser,
  output wire logic                                    m_tvalid,
  input  wire logic                                    m_tready
);
  localparam int IB  = sdw_pkg::IN_BYTES;
  localparam int OB  = sdw_pkg::OUT_BYTES;
  localparam int WB  = sdw_pkg::WIDE_B;
  localparam int UB  = sdw_pkg::UB_PW;
  localparam int IW  = sdw_pkg::IN_W;
  localparam int OW  = sdw_pkg::OUT_W;

  // ==========================================================
  // Configuration checks
  generate
    if (IB < sdw_pkg::MIN_BYTES || IB > sdw_pkg::MAX_BYTES) begin : g_bad_in
      $error("input byte width out of range"); // [RULE1]
    end
    if (OB < sdw_pkg::MIN_BYTES || OB > sdw_pkg::MAX_BYTES) begin : g_bad_out
      $error("output byte width out of range"); // [RULE2]
    end
    if (IB == OB) begin : g_bad_eq
      $error("input and output widths must differ"); // [RULE3]
    end
    // Only whole ratios are built; a partial ratio would need a shifter
    if (sdw_pkg::WIDE_B % sdw_pkg::NARR_B != 0) begin : g_bad_ratio
      $error("wider port must be a whole multiple of the narrower");
    end
    if (sdw_pkg::ID_W > sdw_pkg::MAX_SIDE_W) begin : g_bad_id
      $error("stream id too wide"); // [RULE7]
    end
    if (sdw_pkg::DEST_W > sdw_pkg::MAX_SIDE_W) begin : g_bad_dest
      $error("destination too wide"); // [RULE8]
    end
  endgenerate

  // ==========================================================
  // State
  typedef struct packed {
    logic [sdw_pkg::WIDE_W-1:0]     buf_data;
    logic [WB-1:0]                  buf_keep;
    logic [WB-1:0]                  buf_strb;
    logic [WB*UB-1:0]               buf_user;
    logic                           buf_last;
    logic [sdw_pkg::ID_PW-1:0]      buf_id;
    logic [sdw_pkg::DEST_PW-1:0]    buf_dest;
    logic [sdw_pkg::IDX_W-1:0]      idx;
    logic                           buf_v;
    logic [OW-1:0]                  m_data;
    logic [OB-1:0]                  m_keep;
    logic [OB-1:0]                  m_strb;
    logic [OB*UB-1:0]               m_user;
    logic                           m_last;
    logic [sdw_pkg::ID_PW-1:0]      m_id;
    logic [sdw_pkg::DEST_PW-1:0]    m_dest;
    logic                           m_valid;
  } sdw_conv_st_t;

  sdw_conv_st_t       r;
  sdw_conv_st_t       n;
  sdw_pkg::sdw_beat_t s_beat;
  sdw_pkg::sdw_beat_t in_b;
  logic               ce;
  logic               pop;
  logic               last_slice;

  // ==========================================================
  // Input side
  // Without the enable the block runs on every edge
  assign ce = (sdw_pkg::ACLKEN_EN != 0) ? aclken : 1'b1; // [RULE10]

  // Absent qualifiers are replaced so the repacking never sees them
  assign s_beat.data = s_tdata;
  assign s_beat.keep = (sdw_pkg::KEEP_EN != 0) ? s_tkeep : '1;
  assign s_beat.strb = (sdw_pkg::STRB_EN != 0) ? s_tstrb : '0; // [RULE5]
  assign s_beat.last = (sdw_pkg::LAST_EN != 0) ? s_tlast : 1'b0; // [RULE6]
  assign s_beat.id   = (sdw_pkg::ID_W > 0) ? s_tid : '0; // [RULE7]
  assign s_beat.dest = (sdw_pkg::DEST_W > 0) ? s_tdest : '0; // [RULE8]
  assign s_beat.user = (sdw_pkg::USER_BPB > 0) ? s_tuser : '0; // [RULE9]

  sdw_fifo_if #(.W(sdw_pkg::BEAT_W)) fq ();

  assign fq.in_data   = s_beat;
  assign fq.in_valid  = s_tvalid;
  assign fq.ce        = ce;
  assign fq.out_ready = pop;
  assign s_tready     = fq.in_ready;
  assign in_b         = fq.out_data;

  sdw_fifo #(
    .W     (sdw_pkg::BEAT_W),
    .DEPTH (sdw_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .q       (fq)
  );

  // ==========================================================
  // Repacking
  // Widening fills one slot per beat; narrowing takes the whole beat
  // and hands it out one slice at a time.
  assign last_slice = sdw_pkg::UPSIZE || r.idx == sdw_pkg::IDX_LAST;

  always_comb begin
    n   = r;
    pop = 1'b0;
    if (ce) begin // [RULE12]
      if (r.m_valid && m_tready) begin
        n.m_valid = 1'b0;
      end
      if (r.buf_v && !n.m_valid) begin
        n.m_data  = r.buf_data[r.idx*OW +: OW]; // [RULE11]
        n.m_keep  = r.buf_keep[r.idx*OB +: OB]; // [RULE4]
        n.m_strb  = r.buf_strb[r.idx*OB +: OB]; // [RULE5]
        n.m_user  = r.buf_user[r.idx*OB*UB +: OB*UB]; // [RULE11]
        n.m_last  = r.buf_last && last_slice; // [RULE6]
        n.m_id    = r.buf_id;
        n.m_dest  = r.buf_dest;
        n.m_valid = 1'b1;
        if (last_slice) begin
          n.buf_v = 1'b0;
          n.idx   = '0;
        end else begin
          n.idx = r.idx + sdw_pkg::IDX_ONE;
        end
      end
      if (!n.buf_v && fq.out_valid) begin
        pop = 1'b1;
        // A fresh output beat starts with every lane null
        if (n.idx == '0) begin
          n.buf_keep = '0; // [RULE4]
          n.buf_strb = '0;
          n.buf_user = '0;
        end
        n.buf_data[n.idx*IW +: IW]     = in_b.data; // [RULE11]
        n.buf_keep[n.idx*IB +: IB]     = in_b.keep;
        n.buf_strb[n.idx*IB +: IB]     = in_b.strb;
        n.buf_user[n.idx*IB*UB +: IB*UB] = in_b.user; // [RULE9]
        n.buf_last = in_b.last;
        n.buf_id   = in_b.id; // [RULE7]
        n.buf_dest = in_b.dest; // [RULE8]
        // A packet end closes the wide beat early
        if (!sdw_pkg::UPSIZE || in_b.last ||
            n.idx == sdw_pkg::IDX_LAST) begin
          n.buf_v = 1'b1;
          n.idx   = '0;
        end else begin
          n.idx = n.idx + sdw_pkg::IDX_ONE;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // Output side
  assign m_tdata  = r.m_data;
  assign m_tkeep  = r.m_keep;
  assign m_tstrb  = r.m_strb;
  assign m_tlast  = r.m_last;
  assign m_tid    = r.m_id;
  assign m_tdest  = r.m_dest;
  assign m_tuser  = r.m_user;
  assign m_tvalid = r.m_valid;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_ce_hold;
    !ce |=> r == $past(r);
  endproperty
  a_ce_hold: assert property (p_ce_hold) // [RULE12]
    else $error("state moved with clock enable low");

  property p_out_stable;
    r.m_valid && !(m_tready && ce) |=>
      r.m_valid && $stable(r.m_data) && $stable(r.m_last);
  endproperty
  a_out_stable: assert property (p_out_stable) // [RULE12]
    else $error("output payload changed before acceptance");

  property p_buf_drain;
    ce && r.buf_v && !r.m_valid |=> r.m_valid;
  endproperty
  a_buf_drain: assert property (p_buf_drain) // [RULE12]
    else $error("ready output beat was not presented");

  property p_full_keep;
    (!sdw_pkg::KEEP_OUT || sdw_pkg::KEEP_EN == 0) && r.m_valid &&
      !r.m_last |-> &r.m_keep;
  endproperty
  a_full_keep: assert property (p_full_keep) // [RULE4]
    else $error("null lane inside a non-final beat");

  property p_strb_off;
    sdw_pkg::STRB_EN == 0 |-> r.m_strb == '0;
  endproperty
  a_strb_off: assert property (p_strb_off) // [RULE5]
    else $error("strobe driven while disabled");

  property p_last_off;
    sdw_pkg::LAST_EN == 0 |-> !r.m_last;
  endproperty
  a_last_off: assert property (p_last_off) // [RULE6]
    else $error("packet end driven while disabled");

  property p_side_off;
    (sdw_pkg::ID_W == 0 |-> r.m_id == '0) and
    (sdw_pkg::DEST_W == 0 |-> r.m_dest == '0) and
    (sdw_pkg::USER_BPB == 0 |-> r.m_user == '0);
  endproperty
  a_side_off: assert property (p_side_off) // [RULE9]
    else $error("absent sideband driven");

  property p_slot0;
    pop && !r.buf_v && r.idx == '0 |=>
      r.buf_data[IW-1:0] == $past(in_b.data);
  endproperty
  a_slot0: assert property (p_slot0) // [RULE11]
    else $error("first beat not in lowest lanes");

  property p_side_stable;
    r.m_valid && !(m_tready && ce) |=>
      $stable(r.m_keep) && $stable(r.m_strb) && $stable(r.m_user) &&
      $stable(r.m_id) && $stable(r.m_dest);
  endproperty
  a_side_stable: assert property (p_side_stable) // [RULE12]
    else $error("output sideband changed before acceptance");

  // Last input beat of a full wide word lands in the top lanes
  property p_slot_top;
    sdw_pkg::UPSIZE && pop && !r.buf_v && r.idx == sdw_pkg::IDX_LAST |=>
      r.buf_v && r.buf_data[sdw_pkg::WIDE_W-1 -: IW] == $past(in_b.data);
  endproperty
  a_slot_top: assert property (p_slot_top) // [RULE11]
    else $error("final beat not in highest lanes");

  property p_out_low;
    ce && r.buf_v && !r.m_valid && r.idx == '0 |=>
      r.m_data == $past(r.buf_data[OW-1:0]);
  endproperty
  a_out_low: assert property (p_out_low) // [RULE11]
    else $error("first output slice not from lowest lanes");

  property p_pop_fill;
    pop |=> r.buf_v || r.idx != '0;
  endproperty
  a_pop_fill: assert property (p_pop_fill) // [RULE11]
    else $error("popped beat left no trace in the packer");

  property p_drop_valid;
    ce && r.m_valid && m_tready && !r.buf_v |=> !r.m_valid;
  endproperty
  a_drop_valid: assert property (p_drop_valid) // [RULE12]
    else $error("accepted beat presented twice");

  property p_idx_range;
    r.idx <= sdw_pkg::IDX_LAST;
  endproperty
  a_idx_range: assert property (p_idx_range) // [RULE11]
    else $error("slot index beyond the ratio");

  property p_id_follow;
    ce && r.buf_v && !r.m_valid |=>
      r.m_id == $past(r.buf_id) && r.m_dest == $past(r.buf_dest);
  endproperty
  a_id_follow: assert property (p_id_follow) // [RULE7]
    else $error("stream id or destination did not follow its bytes");
endmodule // sdw_conv

// ==== sdw_sink_model.sv ====
// Downstream partner: takes output beats, stalls on request, checks holds
`timescale 1ns/10ps
module sdw_sink_model (
  input  wire logic                      sys_clk,
  input  wire logic                      resetn,
  input  wire logic [1:0]                mode,
  input  wire logic [sdw_pkg::OUT_W-1:0] m_tdata,
  input  wire logic                      m_tvalid,
  output logic                           m_tready,
  output int                             viol
);
  logic [sdw_pkg::OUT_W-1:0] rx_q[$];
  logic [sdw_pkg::OUT_W-1:0] held_r;
  logic                      wait_r;
  logic [1:0]                ph_r;
  // ==========================================================
  // Acceptance
  // Mode 0 always ready, 1 ready one cycle in three, 2 stopped
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      m_tready <= 1'b0;
      wait_r   <= 1'b0;
      ph_r     <= 2'h0;
      viol     <= 0;
    end else begin
      ph_r     <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
      m_tready <= (mode == 2'h0) || (mode == 2'h1 && ph_r == 2'h2);
      // A stalled beat must not move or vanish
      if (wait_r && (m_tvalid !== 1'b1 || m_tdata !== held_r))
        viol <= viol + 1;
      wait_r <= m_tvalid && !m_tready;
      held_r <= m_tdata;
      if (m_tvalid === 1'b1 && m_tready)
        rx_q.push_back(m_tdata);
    end
  end
endmodule // sdw_sink_model

// ==== sdw_conv_bench.sv ====
// Self-checking bench for the widening stream converter
`timescale 1ns/10ps
module sdw_conv_bench;
  localparam int LIMIT = 20000;
  localparam int IB    = sdw_pkg::IN_BYTES;
  localparam int OB    = sdw_pkg::OUT_BYTES;
  localparam int IW    = sdw_pkg::IN_W;
  localparam int IDW   = sdw_pkg::ID_PW;
  localparam int DW    = sdw_pkg::DEST_PW;
  localparam int UI    = IB * sdw_pkg::UB_PW;
  localparam int UO    = OB * sdw_pkg::UB_PW;
  logic             sys_clk;
  logic             resetn;
  logic             aclken;
  logic             s_tvalid;
  logic             s_tready;
  logic             s_tlast;
  logic             m_tvalid;
  logic             m_tready;
  logic             m_tlast;
  logic [IW-1:0]    s_tdata;
  logic [IB-1:0]    s_tkeep;
  logic [IB-1:0]    s_tstrb;
  logic [IDW-1:0]   s_tid;
  logic [IDW-1:0]   m_tid;
  logic [DW-1:0]    s_tdest;
  logic [DW-1:0]    m_tdest;
  logic [UI-1:0]    s_tuser;
  logic [UO-1:0]    m_tuser;
  logic [sdw_pkg::OUT_W-1:0] m_tdata;
  logic [OB-1:0]    m_tkeep;
  logic [OB-1:0]    m_tstrb;
  logic [1:0]       mode;
  logic [63:0]      side_r;
  logic [IW-1:0]    exp_b[$];
  int               viol;
  int               bad_count;
  int               total_checks;
  int               cyc;

  sdw_conv i_dut (.sys_clk(sys_clk), .resetn(resetn), .aclken(aclken),
    .s_tdata(s_tdata), .s_tkeep(s_tkeep), .s_tstrb(s_tstrb),
    .s_tlast(s_tlast), .s_tid(s_tid), .s_tdest(s_tdest),
    .s_tuser(s_tuser), .s_tvalid(s_tvalid), .s_tready(s_tready),
    .m_tdata(m_tdata), .m_tkeep(m_tkeep), .m_tstrb(m_tstrb),
    .m_tlast(m_tlast), .m_tid(m_tid), .m_tdest(m_tdest),
    .m_tuser(m_tuser), .m_tvalid(m_tvalid), .m_tready(m_tready));
  sdw_sink_model i_sink (.sys_clk(sys_clk), .resetn(resetn), .mode(mode),
    .m_tdata(m_tdata), .m_tvalid(m_tvalid), .m_tready(m_tready),
    .viol(viol));

  // ==========================================================
  // Clock, timeout and sideband watch
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    // Keep is inverted so a null lane shows up as a set bit
    if (m_tvalid === 1'b1)
      side_r <= side_r | 64'({~m_tkeep, m_tlast, m_tstrb, m_tid, m_tdest,
                              m_tuser});
    if (cyc == LIMIT) begin
      bad_count++;
      summarize();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Sidebands follow the data so a repeated offer stays identical
  task automatic offer(input logic [IW-1:0] d);
    s_tvalid <= 1'b1;
    s_tdata  <= d;
    s_tkeep  <= IB'(d);
    s_tstrb  <= IB'(~d);
    s_tlast  <= d[0];
    s_tid    <= IDW'(d);
    s_tdest  <= DW'(~d);
    s_tuser  <= UI'(d);
  endtask
  task automatic send(input logic [IW-1:0] d);
    offer(d);
    do @(posedge sys_clk); while (s_tready !== 1'b1);
    exp_b.push_back(d);
  endtask
  task automatic idle();
    s_tvalid <= 1'b0;
    s_tdata  <= ~s_tdata;
  endtask
  task automatic check_rx();
    logic [sdw_pkg::OUT_W-1:0] w;
    int n;
    n = 0;
    while (i_sink.rx_q.size() * sdw_pkg::RATIO < exp_b.size() && n < 300)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(64'(i_sink.rx_q.size() * sdw_pkg::RATIO),
        64'(exp_b.size()));
    while (i_sink.rx_q.size() > 0 && exp_b.size() >= sdw_pkg::RATIO) begin
      for (int j = 0; j < sdw_pkg::RATIO; j++)
        w[j*IW +: IW] = exp_b.pop_front();
      chk(64'(i_sink.rx_q.pop_front()), 64'(w));
    end
    exp_b.delete();
    i_sink.rx_q.delete();
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_pack(input logic [1:0] m);
    mode <= m;
    for (int i = 0; i < 6; i++)
      send(IW'(8'h11 * (i + 1)));
    idle();
    check_rx();
    chk(64'(viol), 64'h0);
  endtask
  // Queue fills while the far side stops, then drains in order
  task automatic t_fill();
    int acc;
    int miss;
    acc = 0;
    miss = 0;
    mode <= 2'h2;
    offer(IW'(8'h80));
    while (miss < 4 && acc < 16) begin
      @(posedge sys_clk);
      if (s_tready === 1'b1) begin
        exp_b.push_back(s_tdata);
        acc++;
        offer(s_tdata + IW'(8'h01));
      end else
        miss++;
    end
    chk(64'(s_tready), 64'h0);
    chk(64'(acc >= 8 && acc <= 12), 64'h1);
    mode <= 2'h0;
    send(s_tdata);
    if (acc % 2 == 0)
      send(s_tdata + IW'(8'h01));
    idle();
    check_rx();
    chk(64'(s_tready), 64'h1);
    chk(64'(viol), 64'h0);
  endtask
  // Enable is absent in this build, so a low level must not stall
  task automatic t_clken();
    aclken <= 1'b0;
    t_pack(2'h0);
    aclken <= 1'b1;
  endtask

  task automatic summarize();
    $display("Checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    resetn = 1'b0;
    aclken = 1'b1;
    mode = 2'h0;
    side_r = 64'h0;
    s_tvalid = 1'b0;
    s_tdata = '0;
    s_tkeep = '0;
    s_tstrb = '0;
    s_tlast = 1'b0;
    s_tid = '0;
    s_tdest = '0;
    s_tuser = '0;
    repeat (20) @(posedge sys_clk);
    chk(64'({s_tready, m_tvalid}), 64'h2);
    chk(64'(m_tdata), 64'h0);
    resetn <= 1'b1;
    @(posedge sys_clk);
    chk(64'(m_tvalid), 64'h0);
    t_pack(2'h0);
    t_pack(2'h1);
    t_fill();
    t_clken();
    chk(side_r, 64'h0);
    summarize();
  end
endmodule // sdw_conv_bench
